// ### rtl/raw_count_noise_filter.sv
// Raw count noise filter with touch detection and APB register access.
// Assumes raw counts arrive as one-cycle valid pulses on the system clock.
`timescale 1ns/100ps
`default_nettype none
`include "rnf_consts.svh"
// Operation
// - Median of current and two previous samples
// - Average of current and three previous
// - IIR: (N*x + (256-N)*yprev)/256
// - Smaller N gives heavier smoothing
// - Shift IIR x/2^c + y(1-2^-c), c<=8
// - Shift zero passes the stage input unchanged
// - Enabled filters chain in series
// - Touch when finger signal exceeds threshold
// - Full mode recomputes thresholds every scan
// - Converter settings fixed at initialization
// - Hardware-only mode skips threshold computation
module raw_count_noise_filter
#(
	parameter int W = 16
)
(
	// Clock and reset
	input  wire logic           i_clk_sys,
	input  wire logic           i_nrst,
	// APB slave
	input  wire logic           i_psel,
	input  wire logic           i_penable,
	input  wire logic           i_pwrite,
	input  wire logic [7:0]     i_paddr,
	input  wire logic [31:0]    i_pwdata,
	output logic      [31:0]    o_prdata,
	output logic                o_pready,
	output logic                o_pslverr,
	// Raw count stream
	input  wire logic           i_raw_valid,
	input  wire logic [W-1:0]   i_raw,
	// Results
	output logic                o_filt_valid,
	output logic      [W-1:0]   o_filt,
	output logic                o_touch,
	output rnf_pkg::thr_type    o_thr,
	output rnf_pkg::hwcfg_type  o_hw_cfg,
	output logic                o_irq
);
	// Width check
	generate
		if (W < 4 || W > 16)
		begin : g_bad_w
			$error("W must be 4..16");
		end
	endgenerate

	// Software registers
	rnf_pkg::ctrl_type  ctrl;
	logic [8:0]         iir_n;          // Recursive coefficient N
	logic [3:0]         hw_iir_shift_coeff;
	logic [15:0]        finger_cap;     // Minimum finger signal setting
	logic [7:0]         gain;           // Counts per finger unit
	rnf_pkg::hwcfg_type hwcfg_req;      // Proposed converter settings
	logic [31:0]        man_thr0;
	logic [31:0]        man_thr1;
	logic [2:0]         irq_stat;
	logic [2:0]         irq_mask;
	// Filter state
	logic               primed;         // First count seen
	logic [W-1:0]       x1, x2;         // Raw history
	logic [W-1:0]       a1, a2, a3;     // Averager history
	logic [W-1:0]       iir_prev;
	logic [W-1:0]       hw_prev;
	logic [W-1:0]       baseline;
	logic               cfg_held;
	logic               thr_init;

	// APB decode, zero wait states
	wire acc  = i_psel & i_penable;
	wire wr   = acc & i_pwrite;
	wire hit_ctrl  = i_paddr == `RNF_OFF_CTRL;
	wire hit_n     = i_paddr == `RNF_OFF_IIR_N;
	wire hit_sh    = i_paddr == `RNF_OFF_HW_SHIFT;
	wire hit_fing  = i_paddr == `RNF_OFF_FINGER;
	wire hit_hwcfg = i_paddr == `RNF_OFF_HWCFG;
	wire hit_m0    = i_paddr == `RNF_OFF_MAN_THR0;
	wire hit_m1    = i_paddr == `RNF_OFF_MAN_THR1;
	wire hit_thr   = i_paddr == `RNF_OFF_THR;
	wire hit_filt  = i_paddr == `RNF_OFF_FILT;
	wire hit_stat  = i_paddr == `RNF_OFF_STATUS;
	wire hit_is    = i_paddr == `RNF_OFF_IRQ_STAT;
	wire hit_im    = i_paddr == `RNF_OFF_IRQ_MASK;
	wire mapped = hit_ctrl | hit_n | hit_sh | hit_fing | hit_hwcfg | hit_m0 | hit_m1
		| hit_thr | hit_filt | hit_stat | hit_is | hit_im;
	assign o_pready  = 1'b1;
	assign o_pslverr = acc & ~mapped;
	// Read mux, unmapped reads zero
	wire [31:0] rd_mux =
		hit_ctrl  ? {27'h0, ctrl} :
		hit_n     ? {23'h0, iir_n} :
		hit_sh    ? {28'h0, hw_iir_shift_coeff} :
		hit_fing  ? {8'h0, gain, finger_cap} :
		hit_hwcfg ? hwcfg_req :
		hit_m0    ? man_thr0 :
		hit_m1    ? man_thr1 :
		hit_thr   ? {o_thr.noise, o_thr.finger} :
		hit_filt  ? {16'(baseline), 16'(o_filt)} :
		hit_stat  ? {28'h0, cfg_held, primed, o_touch, ctrl.mode} :
		hit_is    ? {29'h0, irq_stat} :
		hit_im    ? {29'h0, irq_mask} : 32'h0;
	// Read data captured at setup so it stands through the whole access phase
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
			o_prdata <= '0;
		else if (i_psel && !i_penable)
			o_prdata <= rd_mux;
	end

	// Register writes; shift values above 8 are ignored
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			ctrl               <= rnf_pkg::ctrl_type'(`RNF_RST_CTRL);
			iir_n              <= `RNF_RST_IIR_N;
			hw_iir_shift_coeff <= `RNF_RST_HW_SHIFT;
			finger_cap         <= `RNF_RST_FINGER;
			gain               <= `RNF_RST_GAIN;
			hwcfg_req          <= '0;
			man_thr0           <= '0;
			man_thr1           <= '0;
			irq_mask           <= '0;
		end
		else if (wr)
		begin
			if (hit_ctrl)  ctrl <= rnf_pkg::ctrl_type'(i_pwdata[4:0]);
			if (hit_n)     iir_n <= i_pwdata[8:0];
			if (hit_sh && i_pwdata[3:0] <= `RNF_HW_SHIFT_MAX)
				hw_iir_shift_coeff <= i_pwdata[3:0];
			if (hit_fing)  {gain, finger_cap} <= i_pwdata[23:0];
			if (hit_hwcfg) hwcfg_req <= i_pwdata;
			if (hit_m0)    man_thr0 <= i_pwdata;
			if (hit_m1)    man_thr1 <= i_pwdata;
			if (hit_im)    irq_mask <= i_pwdata[2:0];
		end
	end

	// current count stands in for the histories until primed
	wire [W-1:0] hx1 = primed ? x1 : i_raw;
	wire [W-1:0] hx2 = primed ? x2 : i_raw;
	logic [W-1:0] med_out;
	rnf_median3 #(.W(W)) u_med
	(
		.i_a   (i_raw),
		.i_b   (hx1),
		.i_c   (hx2),
		.o_med (med_out)
	);
	wire [W-1:0] s1 = ctrl.med_en ? med_out : i_raw;
	wire [W+1:0] avg_sum = (W+2)'(s1) + (W+2)'(primed ? a1 : s1)
		+ (W+2)'(primed ? a2 : s1) + (W+2)'(primed ? a3 : s1);
	wire [W-1:0] s2 = ctrl.avg_en ? avg_sum[W+1:2] : s1;
	// recursive stage, seeded on first count; smaller N smooths more
	wire [W-1:0] iir_y1  = primed ? iir_prev : s2;
	wire [W+9:0] iir_acc = (W+10)'(iir_n) * (W+10)'(s2)
		+ (W+10)'(`RNF_IIR_K - 10'(iir_n)) * (W+10)'(iir_y1);
	wire [W-1:0] iir_out = iir_acc[W+7:8];
	wire [W-1:0] s3 = ctrl.iir_en ? iir_out : s2;
	// shift recursive stage; c=0 gives s3
	wire [W-1:0] hw_y1  = primed ? hw_prev : s3;
	wire [W:0]   hw_acc = (W+1)'(s3 >> hw_iir_shift_coeff) + (W+1)'(hw_y1)
		- (W+1)'(hw_y1 >> hw_iir_shift_coeff);
	wire [W-1:0] hw_out = hw_acc[W-1:0];
	wire [W-1:0] s4 = ctrl.hw_iir_en ? hw_out : s3;

	// History and output update per sample
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			{x1, x2, a1, a2, a3} <= '0;
			{iir_prev, hw_prev}  <= '0;
			primed               <= 1'b0;
			o_filt               <= '0;
			o_filt_valid         <= 1'b0;
		end
		else
		begin
			o_filt_valid <= i_raw_valid;
			if (i_raw_valid)
			begin
				x1       <= i_raw;
				x2       <= hx1;
				a1       <= s1;
				a2       <= primed ? a1 : s1;
				a3       <= primed ? a2 : s1;
				iir_prev <= iir_out;
				hw_prev  <= hw_out;
				primed   <= 1'b1;
				o_filt   <= s4;
			end
		end
	end

	wire [23:0] f_raw = finger_cap * gain;
	wire [15:0] f_thr = (|f_raw[23:16]) ? 16'hffff : f_raw[15:0];
	rnf_pkg::thr_type auto_thr;
	assign auto_thr = '{low_base_reset: f_thr, neg_noise: f_thr >> 1,
		hysteresis: f_thr >> 3, noise: f_thr >> 1, finger: f_thr};
	rnf_pkg::thr_type man_thr;
	assign man_thr = '{low_base_reset: man_thr1[31:16], neg_noise: man_thr1[15:0],
		hysteresis: man_thr0[31:16] >> 3, noise: man_thr0[31:16],
		finger: man_thr0[15:0]};

	// Thresholds: manual every cycle in hardware-only mode, else start-up once, then every scan in full mode
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			o_thr    <= '0;
			thr_init <= 1'b0;
		end
		else if (ctrl.mode == rnf_pkg::MODE_HW_ONLY)
		begin
			o_thr    <= man_thr;
			thr_init <= 1'b1;
		end
		else if (!thr_init || o_filt_valid)
		begin
			o_thr    <= auto_thr;
			thr_init <= 1'b1;
		end
	end

	// converter settings captured once at first count
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			o_hw_cfg <= '0;
			cfg_held <= 1'b0;
		end
		else if (i_raw_valid && !cfg_held)
		begin
			o_hw_cfg <= hwcfg_req;
			cfg_held <= 1'b1;
		end
	end

	// Finger signal against baseline
	wire signed [W+1:0] diff = (W+2)'(o_filt) - (W+2)'(baseline);
	wire signed [W+1:0] fthr = (W+2)'(o_thr.finger);
	wire signed [W+1:0] hthr = (W+2)'(o_thr.finger) - (W+2)'(o_thr.hysteresis);
	// press above finger level, hold above finger minus hysteresis
	wire next_touch = o_touch ? (diff > hthr) : (diff > fthr);
	wire base_low   = diff < -signed'((W+2)'(o_thr.low_base_reset)); // Signed compare
	wire base_quiet = diff < signed'((W+2)'(o_thr.noise));           // Signed compare

	// Touch and baseline tracking
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			o_touch  <= 1'b0;
			baseline <= '0;
		end
		else if (o_filt_valid)
		begin
			o_touch <= primed && baseline != '0 ? next_touch : 1'b0;
			// First result or a deep dip resets the baseline
			if (baseline == '0 || base_low)
				baseline <= o_filt;
			// Slow drift tracking only while untouched and quiet
			else if (!o_touch && base_quiet)
				baseline <= W'(signed'((W+2)'(baseline)) + (diff >>> 4));
		end
	end

	// Events; a set in the clearing cycle wins
	wire [2:0] ev = {o_filt_valid & o_touch & ~next_touch,
		o_filt_valid & ~o_touch & next_touch & baseline != '0, o_filt_valid};
	wire [2:0] clr = (wr && hit_is) ? i_pwdata[2:0] : 3'h0;
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
			irq_stat <= '0;
		else
			irq_stat <= (irq_stat & ~clr) | ev;
	end
	assign o_irq = |(irq_stat & irq_mask);

	// Checks
	med_bound_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		((i_raw >= med_out) + (hx1 >= med_out) + (hx2 >= med_out) >= 2'd2)
		&& ((i_raw <= med_out) + (hx1 <= med_out) + (hx2 <= med_out) >= 2'd2))
		else $error("median out of range");
	median_path_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		i_raw_valid && ctrl == 5'h01 ##1 1'b1 |-> o_filt == $past(med_out))
		else $error("median output wrong");
	avg_path_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		i_raw_valid && ctrl == 5'h02 |=> o_filt == $past(avg_sum[W+1:2]))
		else $error("average output wrong");
	iir_formula_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		i_raw_valid && primed && ctrl == 5'h04 |=>
		(W+10)'(o_filt) == ((W+10)'($past(iir_n)) * (W+10)'($past(i_raw))
		+ (W+10)'(10'h100 - 10'($past(iir_n))) * (W+10)'($past(iir_prev))) >> 8)
		else $error("iir formula wrong");
	iir_bounded_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		i_raw_valid && primed && ctrl == 5'h04 |=>
		o_filt <= ($past(i_raw) > $past(iir_prev) ? $past(i_raw) : $past(iir_prev)))
		else $error("iir overshoot");
	shift_range_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		hw_iir_shift_coeff <= 4'h8) else $error("shift out of range");
	shift_pass_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		i_raw_valid && ctrl == 5'h08 && hw_iir_shift_coeff == 4'h0 |=> o_filt == $past(i_raw))
		else $error("zero shift not transparent");
	bypass_chain_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		i_raw_valid && ctrl[3:0] == 4'h0 |=> o_filt == $past(i_raw) && o_filt_valid)
		else $error("bypass chain wrong");
	touch_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_filt_valid && !o_touch && primed && baseline != '0 && diff > fthr |=> o_touch)
		else $error("touch not set");
	thr_refresh_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_filt_valid && ctrl.mode == rnf_pkg::MODE_FULL_AUTO |=> o_thr.finger == $past(f_thr))
		else $error("threshold not refreshed");
	cfg_stable_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		cfg_held |=> $stable(o_hw_cfg)) else $error("settings changed");
	thr_manual_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		ctrl.mode == rnf_pkg::MODE_HW_ONLY |=> o_thr.finger == $past(man_thr0[15:0]))
		else $error("manual threshold ignored");
	reset_clear_a: assert property (@(posedge i_clk_sys)
		!i_nrst |=> !o_touch && !primed && irq_stat == 3'h0) else $error("reset state wrong");
endmodule
`default_nettype wire

// ### rtl/rnf_consts.svh
// Constants of the raw count noise filter: offsets, field positions, resets.
// Assumes byte addressing on an APB bus with 32-bit words.
`ifndef RNF_CONSTS_SVH
`define RNF_CONSTS_SVH
// Register byte offsets
`define RNF_OFF_CTRL      8'h00
`define RNF_OFF_IIR_N     8'h04
`define RNF_OFF_HW_SHIFT  8'h08
`define RNF_OFF_FINGER    8'h0c
`define RNF_OFF_HWCFG     8'h10
`define RNF_OFF_MAN_THR0  8'h14
`define RNF_OFF_MAN_THR1  8'h18
`define RNF_OFF_THR       8'h1c
`define RNF_OFF_FILT      8'h20
`define RNF_OFF_STATUS    8'h24
`define RNF_OFF_IRQ_STAT  8'h28
`define RNF_OFF_IRQ_MASK  8'h2c
// Control fields
`define RNF_CTRL_MED      0
`define RNF_CTRL_AVG      1
`define RNF_CTRL_IIR      2
`define RNF_CTRL_HWIIR    3
`define RNF_CTRL_MODE     4
// Interrupt status bits
`define RNF_IRQ_SCAN      0
`define RNF_IRQ_PRESS     1
`define RNF_IRQ_RELEASE   2
// Filter constants
`define RNF_IIR_K         10'h100
`define RNF_HW_SHIFT_MAX  4'h8
// Reset values
`define RNF_RST_CTRL      5'h00
`define RNF_RST_IIR_N     9'h080
`define RNF_RST_HW_SHIFT  4'h0
`define RNF_RST_FINGER    16'h0010
`define RNF_RST_GAIN      8'h04
`endif

// ### rtl/rnf_pkg.sv
// Types shared by the raw count noise filter files.
// Assumes counts of at most 16 bits.
package rnf_pkg;
	// Threshold tuning mode
	typedef enum logic {
		MODE_FULL_AUTO = 1'b0,
		MODE_HW_ONLY   = 1'b1
	} tune_mode_type;
	// Filter enables and mode
	typedef struct packed {
		tune_mode_type mode;
		logic          hw_iir_en;
		logic          iir_en;
		logic          avg_en;
		logic          med_en;
	} ctrl_type;
	// Detection thresholds
	typedef struct packed {
		logic [15:0] low_base_reset;
		logic [15:0] neg_noise;
		logic [15:0] hysteresis;
		logic [15:0] noise;
		logic [15:0] finger;
	} thr_type;
	// Converter settings held after initialization
	typedef struct packed {
		logic [3:0] resolution;
		logic [7:0] comp_idac;
		logic [7:0] mod_idac;
		logic [7:0] sense_div;
		logic [3:0] mod_div;
	} hwcfg_type;
endpackage

// ### rtl/rnf_median3.sv
// Three-input median selector.
// Assumes unsigned inputs of equal width, purely combinational.
`timescale 1ns/100ps
`default_nettype none
module rnf_median3
#(
	parameter int W = 16
)
(
	// Samples
	input  wire logic [W-1:0] i_a,
	input  wire logic [W-1:0] i_b,
	input  wire logic [W-1:0] i_c,
	// Median
	output logic      [W-1:0] o_med
);
	// Pairwise orderings
	wire ab = i_a >= i_b;
	wire bc = i_b >= i_c;
	wire ac = i_a >= i_c;
	assign o_med = (ab == bc) ? i_b : ((ab == ac) ? i_c : i_a);
endmodule
`default_nettype wire

// ### dv/rnf_raw_source.sv
// Model of the sensing converter that hands raw counts to the filter.
// Assumes the bench asks for one count at a time on the system clock.
`timescale 1ns/100ps
`default_nettype none
module rnf_raw_source
(
	// Clock, reset and request
	input  wire logic        i_clk_sys,
	input  wire logic        i_nrst,
	input  wire logic        i_send,
	input  wire logic [15:0] i_value,
	// Count stream
	output logic             o_raw_valid,
	output logic      [15:0] o_raw
);
	// One-cycle pulse per count; idle bus flips so a stale count never looks held
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			o_raw_valid <= 1'b0;
			o_raw       <= 16'h5a5a;
		end
		else
		begin
			o_raw_valid <= i_send;
			o_raw       <= i_send ? i_value : ~o_raw;
		end
	end
endmodule
`default_nettype wire

// ### dv/raw_count_noise_filter_tb.sv
// Self-checking bench for the raw count noise filter.
// Assumes the converter model and the filter share one system clock.
`timescale 1ns/100ps
`default_nettype none
`include "rnf_consts.svh"
module raw_count_noise_filter_tb;
	logic               clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic               send, raw_valid, filt_valid, touch, irq, err;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rd;
	logic [15:0]        val, raw, filt;
	rnf_pkg::thr_type   thr;
	rnf_pkg::hwcfg_type hw_cfg;
	int                 fail_count = 0;
	int                 samples_checked = 0;
	// Far side and block under test
	rnf_raw_source u_src (.i_clk_sys(clk), .i_nrst(nrst), .i_send(send), .i_value(val),
		.o_raw_valid(raw_valid), .o_raw(raw));
	raw_count_noise_filter #(.W(16)) u_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_raw_valid(raw_valid),
		.i_raw(raw), .o_filt_valid(filt_valid), .o_filt(filt), .o_touch(touch), .o_thr(thr),
		.o_hw_cfg(hw_cfg), .o_irq(irq));
	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One APB transfer; only the watchdog bounds the wait for pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic rst();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
	endtask
	// One count in; filtered count checked the cycle after it is taken
	task automatic scan(input logic [15:0] v, input logic [15:0] e);
		@(posedge clk);
		send <= 1'b1;
		val <= v;
		@(posedge clk);
		send <= 1'b0;
		@(posedge clk);
		#1 chk(32'({filt_valid, filt}), 32'({1'b1, e}));
		@(posedge clk);
		#1;
	endtask
	task automatic t_regs();
		rdchk(`RNF_OFF_CTRL, 32'h0);
		rdchk(`RNF_OFF_IIR_N, 32'h80);
		rdchk(`RNF_OFF_FINGER, 32'h0004_0010);
		wr(`RNF_OFF_HW_SHIFT, 32'h9);
		rdchk(`RNF_OFF_HW_SHIFT, 32'h0);
		rdchk(8'h30, 32'h0);
		chk(32'(err), 32'h1);
		$display("register test done");
	endtask
	task automatic t_median();
		rst();
		wr(`RNF_OFF_CTRL, 32'h1);
		scan(16'd10, 16'd10);
		scan(16'd50, 16'd10);
		scan(16'd20, 16'd20);
		$display("median test done");
	endtask
	task automatic t_avg();
		rst();
		wr(`RNF_OFF_CTRL, 32'h2);
		scan(16'd8, 16'd8);
		scan(16'd16, 16'd10);
		scan(16'd24, 16'd14);
		scan(16'd32, 16'd20);
		$display("average test done");
	endtask
	task automatic t_iir();
		for (int n = 64; n <= 128; n += 64)
		begin
			rst();
			wr(`RNF_OFF_CTRL, 32'h4);
			wr(`RNF_OFF_IIR_N, 32'(n));
			scan(16'd1000, 16'd1000);
			scan(16'd2000, 16'((n * 2000 + (256 - n) * 1000) / 256));
		end
		$display("iir test done");
	endtask
	task automatic t_hwiir();
		for (int c = 0; c <= 8; c++)
		begin
			rst();
			wr(`RNF_OFF_CTRL, 32'h8);
			wr(`RNF_OFF_HW_SHIFT, 32'(c));
			scan(16'd1024, 16'd1024);
			scan(16'd2048, 16'(1024 + (1024 >> c)));
		end
		$display("shift iir test done");
	endtask
	task automatic t_chain();
		rst();
		wr(`RNF_OFF_CTRL, 32'h3);
		scan(16'd10, 16'd10);
		scan(16'd50, 16'd10);
		scan(16'd20, 16'd12);
		$display("chain test done");
	endtask
	task automatic t_touch();
		rst();
		repeat (2) @(posedge clk);
		#1 chk(32'({thr.finger, thr.hysteresis}), 32'h0040_0008);
		chk(32'({thr.noise, thr.neg_noise}), 32'h0020_0020);
		chk(32'(thr.low_base_reset), 32'h40);
		wr(`RNF_OFF_IRQ_MASK, 32'h2);
		scan(16'd1000, 16'd1000);
		scan(16'd1060, 16'd1060);
		chk(32'({touch, irq}), 32'h0);
		scan(16'd1100, 16'd1100);
		chk(32'({touch, irq}), 32'h3);
		rdchk(`RNF_OFF_IRQ_STAT, 32'h3);
		wr(`RNF_OFF_IRQ_STAT, 32'h2);
		#1 chk(32'(irq), 32'h0);
		scan(16'd1060, 16'd1060);
		chk(32'(touch), 32'h1);
		scan(16'd1050, 16'd1050);
		chk(32'({touch, irq}), 32'h0);
		rdchk(`RNF_OFF_IRQ_STAT, 32'h5);
		wr(`RNF_OFF_FINGER, 32'h0004_0020);
		scan(16'd1000, 16'd1000);
		chk(32'({thr.finger, thr.hysteresis}), 32'h0080_0010);
		rdchk(`RNF_OFF_THR, 32'h0040_0080);
		rdchk(`RNF_OFF_STATUS, 32'hc);
		scan(16'd900, 16'd900);
		rdchk(`RNF_OFF_FILT, 32'h03e1_0384);
		scan(16'd800, 16'd800);
		rdchk(`RNF_OFF_FILT, 32'h0320_0320);
		$display("touch test done");
	endtask
	task automatic t_hwonly();
		rst();
		wr(`RNF_OFF_HWCFG, 32'h2345_6789);
		wr(`RNF_OFF_MAN_THR0, 32'h0010_0030);
		wr(`RNF_OFF_MAN_THR1, 32'h0050_0060);
		wr(`RNF_OFF_CTRL, 32'h10);
		scan(16'd500, 16'd500);
		chk(32'({thr.finger, thr.noise}), 32'h0030_0010);
		chk(32'({thr.low_base_reset, thr.neg_noise}), 32'h0050_0060);
		chk(32'(thr.hysteresis), 32'h2);
		chk(32'(hw_cfg), 32'h2345_6789);
		wr(`RNF_OFF_HWCFG, 32'h0);
		scan(16'd500, 16'd500);
		chk(32'(hw_cfg), 32'h2345_6789);
		$display("hardware only test done");
	endtask
	// Watchdog well beyond the few hundred cycles the tests take
	initial
	begin
		#(25 * 20000);
		fail_count++;
		end_sim();
	end
	// Main sequence
	initial
	begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		send = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		val = 16'h0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_median();
		t_avg();
		t_iir();
		t_hwiir();
		t_chain();
		t_touch();
		t_hwonly();
		end_sim();
	end
endmodule
`default_nettype wire
